//--- cidec_regs.svh
// Constants of the instruction class decoder
`ifndef CIDEC_REGS_SVH
`define CIDEC_REGS_SVH
`define CIDEC_KEY_W       8
`define CIDEC_MAP_DEPTH   256
`define CIDEC_LEN_SHORT   3'h2
`define CIDEC_LEN_LONG    3'h4
`define CIDEC_STEP_NONE   2'h0
`define CIDEC_STEP_ONE    2'h1
`define CIDEC_STEP_TWO    2'h2
`define CIDEC_WORD_ZERO   16'h0000
`define CIDEC_LENOK_NONE  2'h0
`define CIDEC_LENOK_SHORT 2'h1
`define CIDEC_LENOK_LONG  2'h2
`define CIDEC_LENOK_BOTH  2'h3
`endif

//--- cidec_pkg.sv
// Types and length table of the instruction class decoder
`default_nettype none
`include "cidec_regs.svh"
package cidec_pkg;

  typedef enum logic [5:0] {
    CL_ILLEGAL, CL_ADD, CL_ADD_CARRY, CL_SUB, CL_SUB_CARRY, CL_COMPARE,
    CL_MULTIPLY, CL_DIVIDE_WORD, CL_DIVIDE_LONG, CL_COMPLEMENT, CL_NEGATE,
    CL_LOGIC_AND, CL_LOGIC_OR, CL_LOGIC_XOR, CL_BIT_SET_CLEAR, CL_BIT_COPY,
    CL_BIT_LOGIC, CL_BIT_COMPARE, CL_FIELD_MODIFY, CL_COMPARE_DEC,
    CL_COMPARE_INC, CL_NORMALIZE, CL_SHIFT, CL_ROTATE, CL_SHIFT_ARITH,
    CL_MOVE, CL_MOVE_EXTEND, CL_JUMP, CL_JUMP_SEG, CL_BRANCH_SET,
    CL_BRANCH_CLEAR, CL_CALL, CL_CALL_SEG, CL_PUSH_CALL, CL_TRAP,
    CL_PUSH_POP, CL_PUSH_LOAD, CL_RETURN, CL_RETURN_SEG, CL_RETURN_INT,
    CL_SW_BREAK, CL_SW_RESET, CL_IDLE, CL_POWER_DOWN, CL_WATCHDOG,
    CL_INIT_LOCK, CL_ATOMIC, CL_EXT_REG, CL_EXT_PAGE_SEG, CL_NOP,
    CL_MAC_ARITH, CL_MAC_LOAD_STORE
  } cidec_class_t;

  // One opcode map entry, keyed by the first opcode byte
  typedef struct packed {
    cidec_class_t cls;
    logic         byteOp;
    logic         flavor;
    logic         longForm;
  } cidec_map_t;

  typedef struct packed {
    cidec_class_t cls;
    logic [2:0]   lenBytes;
    logic         byteOp;
    logic         signedOp;
    logic         useCarry;
    logic [1:0]   step;
    logic         signExt;
    logic         fieldHigh;
    logic         invertBit;
    logic         modifyBit;
    logic         pushFirst;
    logic         dividendLong;
    logic         destSecond;
    logic         nmiConflict;
    logic [7:0]   immByte;
  } cidec_dec_t;

  // Bit 0: 2-byte form allowed, bit 1: 4-byte form allowed
  function automatic logic [1:0] cidec_len_mask(cidec_class_t c);
    unique case (c)
      CL_ADD, CL_ADD_CARRY, CL_SUB, CL_SUB_CARRY, CL_COMPARE, CL_MULTIPLY,
      CL_LOGIC_AND, CL_LOGIC_OR, CL_LOGIC_XOR, CL_COMPARE_DEC,
      CL_COMPARE_INC, CL_MOVE, CL_MOVE_EXTEND, CL_EXT_PAGE_SEG:
        cidec_len_mask = `CIDEC_LENOK_BOTH;
      CL_DIVIDE_WORD, CL_DIVIDE_LONG, CL_COMPLEMENT, CL_NEGATE,
      CL_BIT_SET_CLEAR, CL_NORMALIZE, CL_SHIFT, CL_ROTATE, CL_SHIFT_ARITH,
      CL_TRAP, CL_PUSH_POP, CL_RETURN, CL_RETURN_SEG, CL_RETURN_INT,
      CL_SW_BREAK, CL_ATOMIC, CL_EXT_REG, CL_NOP:
        cidec_len_mask = `CIDEC_LENOK_SHORT;
      CL_BIT_COPY, CL_BIT_LOGIC, CL_BIT_COMPARE, CL_FIELD_MODIFY,
      CL_JUMP, CL_JUMP_SEG, CL_BRANCH_SET, CL_BRANCH_CLEAR, CL_CALL,
      CL_CALL_SEG, CL_PUSH_CALL, CL_PUSH_LOAD, CL_SW_RESET, CL_IDLE,
      CL_POWER_DOWN, CL_WATCHDOG, CL_INIT_LOCK, CL_MAC_ARITH,
      CL_MAC_LOAD_STORE:
        cidec_len_mask = `CIDEC_LENOK_LONG;
      default:
        cidec_len_mask = `CIDEC_LENOK_NONE;
    endcase
  endfunction

endpackage
`default_nettype wire

//--- cidec_opmap.sv
// Loadable opcode map: first opcode byte to class entry
`timescale 1ns/1ps
`default_nettype none
`include "cidec_regs.svh"
module cidec_opmap (
  input  wire logic                     sys_clk,   // CPU clock
  input  wire logic                     reset,     // Sync reset
  input  wire logic                     mapWe,     // Entry write strobe
  input  wire logic [`CIDEC_KEY_W-1:0]  mapKey,    // Entry written
  input  wire cidec_pkg::cidec_map_t    mapEntry,  // Entry value
  input  wire logic [`CIDEC_KEY_W-1:0]  lookKey,   // Key looked up
  output cidec_pkg::cidec_map_t         lookEntry, // Entry found
  output logic                          lookHit    // Entry loaded
);
  cidec_pkg::cidec_map_t           mapMem [`CIDEC_MAP_DEPTH];
  logic [`CIDEC_MAP_DEPTH-1:0]     loaded_q;

  // Bit patterns come from the supplied map, not from this block
  always_ff @(posedge sys_clk) begin
    if (mapWe) begin
      mapMem[mapKey] <= mapEntry; // RULE19
    end
  end

  // Only reset the valid bits; contents are don't-care until loaded
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      loaded_q <= '0;
    end else if (mapWe) begin
      loaded_q[mapKey] <= 1'b1; // RULE19
    end
  end

  assign lookEntry = mapMem[lookKey];
  assign lookHit   = loaded_q[lookKey];
endmodule
`default_nettype wire

//--- cidec_flavor.sv
// Turns a map entry into the decoded operation fields
`timescale 1ns/1ps
`default_nettype none
`include "cidec_regs.svh"
module cidec_flavor (
  input  wire cidec_pkg::cidec_map_t entry,     // Map entry
  input  wire logic [15:0]           firstWord, // First opcode word
  input  wire logic                  nmiLow,    // Synced NMI is low
  output cidec_pkg::cidec_dec_t      dec        // Decoded fields
);
  cidec_pkg::cidec_class_t c;
  logic widthSel;
  logic signSel;
  logic stepSel;

  assign c = entry.cls;
  assign widthSel = c inside {cidec_pkg::CL_ADD, cidec_pkg::CL_ADD_CARRY,
    cidec_pkg::CL_SUB, cidec_pkg::CL_SUB_CARRY, cidec_pkg::CL_COMPARE,
    cidec_pkg::CL_COMPLEMENT, cidec_pkg::CL_NEGATE, cidec_pkg::CL_LOGIC_AND,
    cidec_pkg::CL_LOGIC_OR, cidec_pkg::CL_LOGIC_XOR, cidec_pkg::CL_MOVE};
  assign signSel = c inside {cidec_pkg::CL_MULTIPLY,
    cidec_pkg::CL_DIVIDE_WORD, cidec_pkg::CL_DIVIDE_LONG};
  assign stepSel = c inside {cidec_pkg::CL_COMPARE_DEC,
    cidec_pkg::CL_COMPARE_INC};

  assign dec.cls = c;
  assign dec.lenBytes = entry.longForm ? `CIDEC_LEN_LONG : `CIDEC_LEN_SHORT;
  assign dec.byteOp = entry.byteOp && widthSel; // RULE1
  assign dec.signedOp = entry.flavor && signSel; // RULE3
  assign dec.useCarry = c inside {cidec_pkg::CL_ADD_CARRY,
    cidec_pkg::CL_SUB_CARRY}; // RULE2
  assign dec.step = !stepSel ? `CIDEC_STEP_NONE :
    entry.flavor ? `CIDEC_STEP_TWO : `CIDEC_STEP_ONE; // RULE6
  // Arithmetic shift and sign-extending move both fill with the sign
  assign dec.signExt = (c == cidec_pkg::CL_SHIFT_ARITH) ||
    (c == cidec_pkg::CL_MOVE_EXTEND && entry.flavor); // RULE8 RULE9
  assign dec.fieldHigh = entry.flavor &&
    c == cidec_pkg::CL_FIELD_MODIFY; // RULE10
  assign dec.invertBit = entry.flavor && c == cidec_pkg::CL_BIT_COPY; // RULE11
  assign dec.modifyBit = entry.flavor && c inside
    {cidec_pkg::CL_BRANCH_SET, cidec_pkg::CL_BRANCH_CLEAR}; // RULE12 RULE13
  assign dec.pushFirst = c inside {cidec_pkg::CL_PUSH_CALL,
    cidec_pkg::CL_PUSH_LOAD}; // RULE14 RULE15
  assign dec.dividendLong = c == cidec_pkg::CL_DIVIDE_LONG; // RULE4 RULE5
  assign dec.destSecond = c == cidec_pkg::CL_NORMALIZE; // RULE7
  assign dec.nmiConflict = c == cidec_pkg::CL_POWER_DOWN && !nmiLow; // RULE17
  assign dec.immByte = firstWord[15:8]; // RULE16
endmodule
`default_nettype wire

//--- cidec_top.sv
// Instruction class decoder between fetch and execute stages
//
// Contract
// [RULE1] Add, subtract, compare in word and byte forms, 2 or 4 bytes
// [RULE2] Carry variants of add and subtract use carry, 2 or 4 bytes
// [RULE3] Multiply takes two 16-bit registers, signed or unsigned
// [RULE4] Word divide uses low product word over 16-bit register, 2 bytes
// [RULE5] Long divide uses 32-bit product register over register, 2 bytes
// [RULE6] Compare then decrement or increment register by 1 or 2
// [RULE7] Normalise count goes to a second register, 2 bytes
// [RULE8] Arithmetic right shift fills with the sign bit, 2 bytes
// [RULE9] Byte to word move extends by sign or by zero
// [RULE10] Masked field modify of high or low byte, 4 bytes
// [RULE11] Bit copy, optionally inverted, is 4 bytes
// [RULE12] Branch on bit set, clearing variant clears bit, 4 bytes
// [RULE13] Branch on bit clear, setting variant sets bit, 4 bytes
// [RULE14] Push then call absolute is 4 bytes
// [RULE15] Push then load register with operand is 4 bytes
// [RULE16] Trap carries an immediate trap number in 2 bytes
// [RULE17] Power down is 4 bytes and expects NMI input low
// [RULE18] Every coprocessor operation, load and store too, is 4 bytes
// [RULE19] Bit patterns come from a separately loaded opcode map
`timescale 1ns/1ps
`default_nettype none
`include "cidec_regs.svh"
module cidec_top (
  input  wire logic                    sys_clk,      // CPU clock 40 MHz
  input  wire logic                    reset,        // Sync reset
  input  wire logic                    nmiPin,       // NMI pin level
  input  wire logic                    mapWe,        // Map write strobe
  input  wire logic [`CIDEC_KEY_W-1:0] mapKey,       // Map key written
  input  wire cidec_pkg::cidec_map_t   mapEntry,     // Map entry value
  input  wire logic                    fetchValid,   // Word offered
  input  wire logic [15:0]             fetchWord,    // Opcode word
  output logic                         fetchReady,   // Word accepted
  input  wire logic                    execReady,    // Execute takes op
  output logic                         decValid,     // Op on output
  output cidec_pkg::cidec_dec_t        decOp,        // Decoded op
  output logic [15:0]                  decOperand,   // Second word
  output logic                         powerDownReq  // Power down pulse
);
  typedef enum logic {ST_FIRST, ST_EXT} cidec_state_t;

  cidec_state_t          state_q, state_d;
  cidec_pkg::cidec_dec_t held_q, held_d;
  cidec_pkg::cidec_dec_t decOp_q, decOp_d;
  cidec_pkg::cidec_dec_t firstDec;
  cidec_pkg::cidec_dec_t rawDec;
  cidec_pkg::cidec_dec_t illegalDec;
  cidec_pkg::cidec_map_t lookEntry;
  logic                  lookHit;
  logic [1:0]            lenMask;
  logic                  codeOk;
  logic                  lenOk;
  logic                  legal;
  logic                  outFree;
  logic                  take;
  logic                  firstTake;
  logic                  goLong;
  logic                  emitShort;
  logic                  emitLong;
  logic                  emitPd;
  logic                  decValid_q, decValid_d;
  logic [15:0]           decOperand_q, decOperand_d;
  logic                  powerDownReq_q, powerDownReq_d;
  logic                  nmiMeta_q;
  logic                  nmiSync_q;

  // Pin passes two flops before anything reads it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nmiMeta_q <= 1'b0;
      nmiSync_q <= 1'b0;
    end else begin
      nmiMeta_q <= nmiPin;
      nmiSync_q <= nmiMeta_q;
    end
  end

  cidec_opmap u_opmap (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .mapWe     (mapWe),
    .mapKey    (mapKey),
    .mapEntry  (mapEntry),
    .lookKey   (fetchWord[`CIDEC_KEY_W-1:0]),
    .lookEntry (lookEntry),
    .lookHit   (lookHit)
  );

  cidec_flavor u_flavor (
    .entry     (lookEntry),
    .firstWord (fetchWord),
    .nmiLow    (!nmiSync_q),
    .dec       (rawDec)
  );

  // A map entry whose length the class cannot have is refused
  assign lenMask = cidec_pkg::cidec_len_mask(lookEntry.cls); // RULE18
  assign codeOk  = lookEntry.cls <= cidec_pkg::CL_MAC_LOAD_STORE;
  assign lenOk   = lookEntry.longForm ? lenMask[1] : lenMask[0];
  assign legal   = lookHit && codeOk && lenOk &&
                   lookEntry.cls != cidec_pkg::CL_ILLEGAL; // RULE19

  always_comb begin
    illegalDec          = '0;
    illegalDec.cls      = cidec_pkg::CL_ILLEGAL;
    illegalDec.lenBytes = `CIDEC_LEN_SHORT;
    illegalDec.immByte  = fetchWord[15:8];
  end

  assign firstDec = legal ? rawDec : illegalDec;

  // Output slot frees when empty or being drained this cycle
  assign outFree    = !decValid_q || execReady;
  assign fetchReady = outFree;
  assign take       = fetchValid && fetchReady;
  assign firstTake  = take && state_q == ST_FIRST;
  assign goLong     = firstTake && legal && lookEntry.longForm; // RULE1
  assign emitShort  = firstTake && !goLong;
  assign emitLong   = take && state_q == ST_EXT;
  assign emitPd     = emitLong && held_q.cls == cidec_pkg::CL_POWER_DOWN &&
                      !held_q.nmiConflict; // RULE17

  assign state_d = goLong ? ST_EXT : emitLong ? ST_FIRST : state_q;
  assign held_d  = goLong ? firstDec : held_q;

  assign decValid_d = (emitShort || emitLong) ? 1'b1 :
                      execReady ? 1'b0 : decValid_q;
  assign decOp_d = emitShort ? firstDec :
                   emitLong ? held_q : decOp_q;
  // Short forms carry no second word; present zero for them
  assign decOperand_d = emitLong ? fetchWord :
                        emitShort ? `CIDEC_WORD_ZERO : decOperand_q;
  assign powerDownReq_d = emitPd;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= ST_FIRST;
      held_q  <= '0;
    end else begin
      state_q <= state_d;
      held_q  <= held_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      decValid_q     <= 1'b0;
      decOp_q        <= '0;
      decOperand_q   <= `CIDEC_WORD_ZERO;
      powerDownReq_q <= 1'b0;
    end else begin
      decValid_q     <= decValid_d;
      decOp_q        <= decOp_d;
      decOperand_q   <= decOperand_d;
      powerDownReq_q <= powerDownReq_d;
    end
  end

  assign decValid     = decValid_q;
  assign decOp        = decOp_q;
  assign decOperand   = decOperand_q;
  assign powerDownReq = powerDownReq_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence sLongTake;
    firstTake && legal && lookEntry.longForm;
  endsequence

  sequence sExtTake;
    state_q == ST_EXT && take;
  endsequence

  sequence sShortTake;
    firstTake && !(legal && lookEntry.longForm);
  endsequence

  sequence sOutStall;
    decValid_q && !execReady;
  endsequence

  AST_LONG_WAITS_EXT: assert property ( // RULE1
    sLongTake |=> state_q == ST_EXT && !decValid_q)
    else $error("long form did not wait for second word");

  AST_EXT_EMITS: assert property ( // RULE1
    sExtTake |=> decValid_q && decOp_q.lenBytes == `CIDEC_LEN_LONG &&
      decOperand_q == $past(fetchWord) && state_q == ST_FIRST)
    else $error("second word not delivered with long op");

  AST_SHORT_EMITS: assert property ( // RULE1
    sShortTake |=> decValid_q && decOp_q.lenBytes == `CIDEC_LEN_SHORT &&
      decOperand_q == `CIDEC_WORD_ZERO)
    else $error("short op not delivered next cycle");

  AST_LONG_PAIR: assert property ( // RULE18
    sLongTake ##1 sExtTake |=> decOp_q.cls == $past(lookEntry.cls, 2))
    else $error("long op lost its first word class");

  AST_OUT_HOLDS: assert property ( // RULE1
    sOutStall |=> decValid_q && $stable(decOp_q) && $stable(decOperand_q))
    else $error("output changed while stalled");

  AST_WIDTH_CLASS: assert property ( // RULE1
    decValid_q && decOp_q.byteOp |-> decOp_q.cls inside
      {cidec_pkg::CL_ADD, cidec_pkg::CL_ADD_CARRY, cidec_pkg::CL_SUB,
       cidec_pkg::CL_SUB_CARRY, cidec_pkg::CL_COMPARE,
       cidec_pkg::CL_COMPLEMENT, cidec_pkg::CL_NEGATE,
       cidec_pkg::CL_LOGIC_AND, cidec_pkg::CL_LOGIC_OR,
       cidec_pkg::CL_LOGIC_XOR, cidec_pkg::CL_MOVE})
    else $error("byte width on a word-only class");

  AST_CARRY: assert property ( // RULE2
    decValid_q |-> decOp_q.useCarry == (decOp_q.cls inside
      {cidec_pkg::CL_ADD_CARRY, cidec_pkg::CL_SUB_CARRY}))
    else $error("carry use does not match class");

  AST_MUL_WORD: assert property ( // RULE3
    decValid_q && decOp_q.cls == cidec_pkg::CL_MULTIPLY |->
      !decOp_q.byteOp && !decOp_q.dividendLong)
    else $error("multiply decoded with wrong width");

  AST_DIV_WORD: assert property ( // RULE4
    decValid_q && decOp_q.cls == cidec_pkg::CL_DIVIDE_WORD |->
      decOp_q.lenBytes == `CIDEC_LEN_SHORT && !decOp_q.dividendLong)
    else $error("word divide length or dividend wrong");

  AST_DIV_LONG: assert property ( // RULE5
    decValid_q && decOp_q.cls == cidec_pkg::CL_DIVIDE_LONG |->
      decOp_q.lenBytes == `CIDEC_LEN_SHORT && decOp_q.dividendLong)
    else $error("long divide length or dividend wrong");

  AST_CMP_STEP: assert property ( // RULE6
    decValid_q |-> (decOp_q.step != `CIDEC_STEP_NONE) ==
      (decOp_q.cls inside {cidec_pkg::CL_COMPARE_DEC,
       cidec_pkg::CL_COMPARE_INC}))
    else $error("register step does not match class");

  AST_NORMALIZE: assert property ( // RULE7
    decValid_q && decOp_q.cls == cidec_pkg::CL_NORMALIZE |->
      decOp_q.lenBytes == `CIDEC_LEN_SHORT && decOp_q.destSecond)
    else $error("normalise op decoded wrong");

  AST_SIGN_SHIFT: assert property ( // RULE8
    decValid_q && decOp_q.cls == cidec_pkg::CL_SHIFT_ARITH |->
      decOp_q.lenBytes == `CIDEC_LEN_SHORT && decOp_q.signExt)
    else $error("arithmetic shift lost sign fill");

  AST_EXTEND_ONLY: assert property ( // RULE9
    decValid_q && decOp_q.signExt |-> decOp_q.cls inside
      {cidec_pkg::CL_SHIFT_ARITH, cidec_pkg::CL_MOVE_EXTEND})
    else $error("sign fill on unrelated class");

  AST_FIELD_LONG: assert property ( // RULE10
    decValid_q && decOp_q.cls == cidec_pkg::CL_FIELD_MODIFY |->
      decOp_q.lenBytes == `CIDEC_LEN_LONG)
    else $error("field modify not four bytes");

  AST_BIT_OPS_LONG: assert property ( // RULE11
    decValid_q && decOp_q.cls inside {cidec_pkg::CL_BIT_COPY,
      cidec_pkg::CL_BRANCH_SET, cidec_pkg::CL_BRANCH_CLEAR} |->
      decOp_q.lenBytes == `CIDEC_LEN_LONG)
    else $error("bit op not four bytes");

  AST_BIT_MODIFY: assert property ( // RULE12
    decValid_q && decOp_q.modifyBit |-> decOp_q.cls inside
      {cidec_pkg::CL_BRANCH_SET, cidec_pkg::CL_BRANCH_CLEAR})
    else $error("bit modify on non-branch class");

  AST_PUSH_FIRST: assert property ( // RULE14
    decValid_q && decOp_q.cls inside {cidec_pkg::CL_PUSH_CALL,
      cidec_pkg::CL_PUSH_LOAD} |->
      decOp_q.pushFirst && decOp_q.lenBytes == `CIDEC_LEN_LONG)
    else $error("push-first op decoded wrong");

  AST_TRAP_SHORT: assert property ( // RULE16
    sShortTake ##0 (legal && lookEntry.cls == cidec_pkg::CL_TRAP) |=>
      decOp_q.immByte == $past(fetchWord[15:8]))
    else $error("trap number not carried");

  AST_PD_NMI: assert property ( // RULE17
    powerDownReq_q |-> decValid_q && !decOp_q.nmiConflict &&
      decOp_q.cls == cidec_pkg::CL_POWER_DOWN &&
      decOp_q.lenBytes == `CIDEC_LEN_LONG)
    else $error("power down request without its op");

  AST_MAC_LONG: assert property ( // RULE18
    decValid_q && decOp_q.cls inside {cidec_pkg::CL_MAC_ARITH,
      cidec_pkg::CL_MAC_LOAD_STORE} |-> decOp_q.lenBytes == `CIDEC_LEN_LONG)
    else $error("coprocessor op not four bytes");

  AST_UNMAPPED: assert property ( // RULE19
    firstTake && !lookHit |=> decValid_q &&
      decOp_q.cls == cidec_pkg::CL_ILLEGAL)
    else $error("unmapped opcode not flagged illegal");
endmodule
`default_nettype wire

//--- cidec_fetch_model.sv
// Fetch stage model feeding opcode words to the decoder
`timescale 1ns/1ps
`default_nettype none
module cidec_fetch_model (
  input  wire logic        sys_clk,    // CPU clock
  input  wire logic        reset,      // Sync reset
  input  wire logic        fetchReady, // Decoder takes word
  input  wire logic        slow,       // Insert idle gaps
  output logic             fetchValid, // Word offered
  output logic [15:0]      fetchWord   // Opcode word
);
  logic [15:0] pend[$];
  logic        gap_q;

  initial begin
    fetchValid = 1'b0;
    fetchWord  = 16'h0000;
    gap_q      = 1'b0;
  end

  task automatic put(input logic [15:0] w);
    pend.push_back(w);
  endtask

  // Word and valid held until taken; idle bus toggles so stale data shows
  always @(posedge sys_clk) begin
    gap_q <= !gap_q;
    if (fetchValid && fetchReady) begin
      void'(pend.pop_front());
    end
    if (!(fetchValid && !fetchReady)) begin
      if (reset || (slow && gap_q) || pend.size() == 0) begin
        fetchValid <= 1'b0;
        fetchWord  <= ~fetchWord;
      end else begin
        fetchValid <= 1'b1;
        fetchWord  <= pend[0];
      end
    end
  end
endmodule
`default_nettype wire

//--- cpu_instruction_class_decoder_test.sv
// Self-checking bench of the instruction class decoder
`timescale 1ns/1ps
`default_nettype none
`include "cidec_regs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module cpu_instruction_class_decoder_test;
  logic                  sys_clk, reset, nmiPin, mapWe, execReady, slow;
  logic                  fetchValid, fetchReady, decValid, powerDownReq;
  logic                  pdSeen;
  logic [7:0]            mapKey, keyQ;
  logic [15:0]           fetchWord, decOperand;
  cidec_pkg::cidec_map_t mapEntry;
  cidec_pkg::cidec_dec_t decOp;
  cidec_pkg::cidec_dec_t gotOp[$];
  logic [15:0]           gotOpd[$];
  int                    mismatches, checked;

  cidec_top uut (.sys_clk(sys_clk), .reset(reset), .nmiPin(nmiPin),
    .mapWe(mapWe), .mapKey(mapKey), .mapEntry(mapEntry),
    .fetchValid(fetchValid), .fetchWord(fetchWord),
    .fetchReady(fetchReady), .execReady(execReady), .decValid(decValid),
    .decOp(decOp), .decOperand(decOperand), .powerDownReq(powerDownReq));

  cidec_fetch_model fm (.sys_clk(sys_clk), .reset(reset),
    .fetchReady(fetchReady), .slow(slow), .fetchValid(fetchValid),
    .fetchWord(fetchWord));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (!reset && decValid && execReady) begin
      gotOp.push_back(decOp);
      gotOpd.push_back(decOperand);
    end
    if (!reset && powerDownReq) pdSeen = 1'b1;
  end

  function automatic logic fieldOf(cidec_pkg::cidec_dec_t d, int id);
    case (id)
      1: fieldOf = d.byteOp;
      2: fieldOf = d.signedOp;
      3: fieldOf = d.useCarry;
      4: fieldOf = d.step == `CIDEC_STEP_TWO;
      5: fieldOf = d.signExt;
      6: fieldOf = d.fieldHigh;
      7: fieldOf = d.invertBit;
      8: fieldOf = d.modifyBit;
      9: fieldOf = d.pushFirst;
      10: fieldOf = d.dividendLong;
      11: fieldOf = d.destSecond;
      12: fieldOf = d.nmiConflict;
      13: fieldOf = pdSeen;
      default: fieldOf = d.step == `CIDEC_STEP_ONE;
    endcase
  endfunction

  task automatic stop_test;
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic waitOps(input int n);
    for (int i = 0; i < 60 && gotOp.size() < n; i++) @(posedge sys_clk) #1;
    `CHK(gotOp.size(), n)
  endtask

  // Map one key, send its words, judge the single op that comes back
  task automatic rc(input cidec_pkg::cidec_class_t c, input logic b, f, l,
                    input logic ok, input int fld, input logic ev);
    cidec_pkg::cidec_dec_t d;
    logic [15:0]           w1, opd;
    w1 = {keyQ ^ 8'h5a, keyQ};
    @(posedge sys_clk);
    mapWe <= c != cidec_pkg::CL_ILLEGAL;
    mapKey <= keyQ;
    mapEntry <= cidec_pkg::cidec_map_t'{c, b, f, l};
    @(posedge sys_clk);
    mapWe <= 1'b0;
    pdSeen = 1'b0;
    fm.put(w1);
    if (ok && l) fm.put({keyQ, 8'h3c});
    waitOps(1);
    if (gotOp.size() > 0) begin
      d = gotOp.pop_front();
      opd = gotOpd.pop_front();
      `CHK(d.cls, ok ? c : cidec_pkg::CL_ILLEGAL)
      `CHK(d.lenBytes, ok && l ? `CIDEC_LEN_LONG : `CIDEC_LEN_SHORT)
      `CHK(opd, ok && l ? {keyQ, 8'h3c} : `CIDEC_WORD_ZERO)
      if (fld != 0) `CHK(fieldOf(d, fld), ev)
      if (c == cidec_pkg::CL_TRAP) `CHK(d.immByte, w1[15:8])
    end
    keyQ = keyQ + 8'h01;
  endtask

  // Execute stalls: decoder must refuse words and hold its op
  task automatic stallCase;
    @(posedge sys_clk);
    execReady <= 1'b0;
    fm.put(16'h0001);
    fm.put(16'h0002);
    repeat (6) @(posedge sys_clk);
    #1;
    `CHK(decValid, 1'b1)
    `CHK(fetchReady, 1'b0)
    `CHK(gotOp.size(), 0)
    @(posedge sys_clk);
    execReady <= 1'b1;
    waitOps(2);
    if (gotOp.size() == 2) begin
      `CHK(gotOp[0].cls, cidec_pkg::CL_ADD)
      `CHK(gotOp[1].cls, cidec_pkg::CL_SUB)
    end
    gotOp.delete();
    gotOpd.delete();
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    stop_test();
  end

  initial begin
    reset = 1'b1;
    nmiPin = 1'b0;
    mapWe = 1'b0;
    mapKey = 8'h00;
    mapEntry = '0;
    execReady = 1'b1;
    slow = 1'b0;
    keyQ = 8'h01;
    mismatches = 0;
    checked = 0;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    rc(cidec_pkg::CL_ADD, 1, 0, 0, 1, 1, 1);
    rc(cidec_pkg::CL_SUB, 0, 0, 0, 1, 1, 0);
    stallCase();
    rc(cidec_pkg::CL_COMPARE, 1, 0, 1, 1, 1, 1);
    rc(cidec_pkg::CL_ADD_CARRY, 0, 0, 1, 1, 3, 1);
    rc(cidec_pkg::CL_SUB_CARRY, 1, 0, 0, 1, 3, 1);
    rc(cidec_pkg::CL_MULTIPLY, 0, 1, 0, 1, 2, 1);
    rc(cidec_pkg::CL_MULTIPLY, 0, 0, 1, 1, 2, 0);
    rc(cidec_pkg::CL_DIVIDE_WORD, 0, 1, 0, 1, 10, 0);
    rc(cidec_pkg::CL_DIVIDE_WORD, 0, 0, 1, 0, 0, 0);
    rc(cidec_pkg::CL_DIVIDE_LONG, 0, 0, 0, 1, 10, 1);
    slow <= 1'b1;
    rc(cidec_pkg::CL_COMPARE_DEC, 0, 1, 1, 1, 4, 1);
    rc(cidec_pkg::CL_COMPARE_INC, 0, 0, 0, 1, 14, 1);
    rc(cidec_pkg::CL_NORMALIZE, 0, 0, 0, 1, 11, 1);
    rc(cidec_pkg::CL_NORMALIZE, 0, 0, 1, 0, 0, 0);
    rc(cidec_pkg::CL_SHIFT_ARITH, 0, 0, 0, 1, 5, 1);
    rc(cidec_pkg::CL_MOVE_EXTEND, 0, 1, 1, 1, 5, 1);
    rc(cidec_pkg::CL_MOVE_EXTEND, 0, 0, 0, 1, 5, 0);
    rc(cidec_pkg::CL_FIELD_MODIFY, 0, 1, 1, 1, 6, 1);
    rc(cidec_pkg::CL_FIELD_MODIFY, 0, 0, 0, 0, 0, 0);
    rc(cidec_pkg::CL_FIELD_MODIFY, 0, 0, 1, 1, 6, 0);
    rc(cidec_pkg::CL_BIT_COPY, 0, 1, 1, 1, 7, 1);
    rc(cidec_pkg::CL_BRANCH_SET, 0, 1, 1, 1, 8, 1);
    rc(cidec_pkg::CL_BRANCH_CLEAR, 0, 0, 1, 1, 8, 0);
    rc(cidec_pkg::CL_BRANCH_CLEAR, 0, 1, 1, 1, 8, 1);
    rc(cidec_pkg::CL_PUSH_CALL, 0, 0, 1, 1, 9, 1);
    rc(cidec_pkg::CL_PUSH_LOAD, 0, 0, 1, 1, 9, 1);
    rc(cidec_pkg::CL_TRAP, 0, 0, 0, 1, 0, 0);
    slow <= 1'b0;
    rc(cidec_pkg::CL_POWER_DOWN, 0, 0, 1, 1, 13, 1);
    @(posedge sys_clk);
    nmiPin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rc(cidec_pkg::CL_POWER_DOWN, 0, 0, 1, 1, 12, 1);
    rc(cidec_pkg::CL_POWER_DOWN, 0, 0, 1, 1, 13, 0);
    @(posedge sys_clk);
    nmiPin <= 1'b0;
    rc(cidec_pkg::CL_MAC_LOAD_STORE, 0, 0, 1, 1, 0, 0);
    rc(cidec_pkg::CL_MAC_ARITH, 0, 0, 0, 0, 0, 0);
    rc(cidec_pkg::CL_ILLEGAL, 0, 0, 0, 0, 0, 0);
    rc(cidec_pkg::cidec_class_t'(6'h3f), 0, 0, 0, 0, 0, 0);
    stop_test();
  end
endmodule
`default_nettype wire
